/* File: include/wfd_cfg.svh */
// Purpose: named offsets, field positions and counts of the word format datapath
// Assumes: included by bare name; definitions only
// Notes:   byte addresses on the plain register port
`ifndef WFD_CFG_SVH
`define WFD_CFG_SVH

// ================================
// register map (byte addresses)
`define WFD_A_CTRL    8'h00
`define WFD_A_OPA     8'h04
`define WFD_A_OPB     8'h08
`define WFD_A_RESH    8'h0c
`define WFD_A_RESL    8'h10
`define WFD_A_STAT    8'h14
`define WFD_A_DEC     8'h18

// ================================
// control register fields
`define WFD_C_OP      2:0
`define WFD_C_UNORM   3
`define WFD_C_IDX     6:4
`define WFD_C_SIZE    10:8
`define WFD_C_POS     14:11
`define WFD_C_CONN    16:15
`define WFD_C_DEST    17
`define WFD_C_EXT     18
`define WFD_C_W       19

// ================================
// status register fields
`define WFD_S_BUSY    0
`define WFD_S_LAMP    1
`define WFD_S_CNT     15:8

// ================================
// formats and counts
`define WFD_EXP_I2F   8'h0f
`define WFD_EXP_LOW   8'h17
`define WFD_EXP_INTMX 8'h17
`define WFD_NIDX      8

`endif

/* File: include/wfd_pkg.sv */
// Purpose: types shared by the word format datapath
// Assumes: field widths match the memory and instruction word layouts
// Notes:   bit 0 of the documented numbering is the msb here
package wfd_pkg;

  // ================================
  // stored memory word: parity, program tags, information
  typedef struct packed {
    logic [1:0]  parity;   // [1] left half, [0] right half
    logic [1:0]  progTag;  // program_tag_bits
    logic [31:0] info;     // left half [31:16], right half [15:0]
  } wfd_mem_word_t;

  // ================================
  // instruction word fields, msb first
  typedef struct packed {
    logic [15:0] addrField; // operand / immediate / shift count
    logic        indirect;  // address field points to new address field
    logic [2:0]  indexSel;  // index register 1..7, 0 none
    logic [11:0] opCode;    // operation_code_field
  } wfd_instr_t;

  // ================================
  // operations started by a control write
  typedef enum logic [2:0] {
    WFD_OP_NORM  = 3'h0,
    WFD_OP_FMUL  = 3'h1,
    WFD_OP_I2F   = 3'h2,
    WFD_OP_F2I   = 3'h3,
    WFD_OP_INDEX = 3'h4,
    WFD_OP_LBYTE = 3'h5,
    WFD_OP_FIX   = 3'h6,
    WFD_OP_NONE  = 3'h7
  } wfd_op_t;

  // ================================
  // sequencer states, one hot
  typedef enum logic [2:0] {
    WFD_ST_IDLE = 3'b001,
    WFD_ST_NORM = 3'b010,
    WFD_ST_DONE = 3'b100
  } wfd_state_t;

endpackage

/* File: core/wfd_datapath.sv */
// Purpose: memory word parity, instruction field decode and data format unit
// Assumes: one clock, synchronous active high reset, memory side strobes are pulses
// Notes:   float single word = fraction [31:8] two's complement, exponent [7:0]
//
// Functional notes
// RQ1: memory word is 36 bits wide
// RQ2: two half-word parity bits on write
// RQ3: read parity check lights lamp, interrupts
// RQ4: parity is odd
// RQ5: info usable as word, halves, bytes
// RQ6: first 16 instruction bits are address
// RQ7: bit 16 set means indirect address
// RQ8: bits 17-19 select index register
// RQ9: last 12 bits are operation code
// RQ10: arithmetic uses two's complement
// RQ11: single float 23+sign, 7+sign exponent
// RQ12: double float low address holds msbs
// RQ13: second word exponent is main minus 23
// RQ14: float multiply yields double format
// RQ15: normalize results unless unnormalized modifier
// RQ16: shift left until bits 0,1 differ
// RQ17: standard fixed is sign plus 15
// RQ18: extended fixed left half holds msbs
// RQ19: integer mode converts on load, store
// RQ20: integer ops normalized or not by modifier
// RQ21: index op updates index, keeps accumulator
// RQ22: logical byte ops sizes 16 to 1
// RQ23: info bits 0-15 left half
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "wfd_cfg.svh"

module wfd_datapath #(
  parameter int NIDX = `WFD_NIDX
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // register port
  input  wire logic [7:0]            regAddr,
  input  wire logic [31:0]           regWrData,
  input  wire logic                  regWrStb,
  input  wire logic                  regRdStb,
  output logic [31:0]                regRdData,
  // memory write side
  input  wire logic                  memWrEn,
  input  wire logic [31:0]           memWrInfo,
  input  wire logic [1:0]            memWrTag,
  output wfd_pkg::wfd_mem_word_t     memWrWord,
  output logic                       memWrValid,
  // memory read side
  input  wire logic                  memRdEn,
  input  wire wfd_pkg::wfd_mem_word_t memRdWord,
  output logic [31:0]                rdInfo,
  output logic [1:0]                 rdTag,
  output logic                       rdValid,
  output logic                       parityIrq,
  output logic                       consoleLamp,
  // instruction decode
  input  wire logic                  instrValid,
  input  wire logic [31:0]           instrWord,
  output wfd_pkg::wfd_instr_t        decodeOut,
  output logic                       decodeValid
);

  // ================================
  // register storage
  logic [`WFD_C_W-1:0]     ctrl_ff;       // operation control fields
  logic [31:0]             opA_ff;        // accumulator side operand
  logic [31:0]             opB_ff;        // memory side operand
  logic [31:0]             resHi_ff;      // lower address result word
  logic [31:0]             resLo_ff;      // higher address result word
  logic [7:0]              errCnt_ff;     // parity errors seen
  logic [47:0]             accFrac_ff;    // working fraction, q1.47
  logic [7:0]              accExp_ff;     // working exponent
  logic                    floatOp_ff;    // result comes from accumulator
  logic [15:0]             idxReg_ff [NIDX]; // index registers
  wfd_pkg::wfd_state_t     state_ff;      // sequencer state
  logic                    parErr;        // read word parity mismatch
  logic                    start;         // operation accepted this cycle
  logic                    clrLamp;       // software lamp clear
  wfd_pkg::wfd_op_t        newOp;         // operation in the write data

  // ================================
  // decode of the register port
  assign newOp   = wfd_pkg::wfd_op_t'(regWrData[`WFD_C_OP]);
  assign start   = regWrStb && (regAddr == `WFD_A_CTRL)
                   && (state_ff == wfd_pkg::WFD_ST_IDLE);
  assign clrLamp = regWrStb && (regAddr == `WFD_A_STAT)
                   && regWrData[`WFD_S_LAMP];

  // ================================
  // memory write: odd parity per half word
  always_ff @(posedge clk) begin
    if (reset) begin
      memWrWord  <= '0;
      memWrValid <= 1'b0;
    end else begin
      memWrValid <= memWrEn;
      if (memWrEn) begin
        memWrWord.info      <= memWrInfo;                // see RQ1
        memWrWord.progTag   <= memWrTag;
        memWrWord.parity[1] <= ~^memWrInfo[31:16];       // see RQ2, see RQ23
        memWrWord.parity[0] <= ~^memWrInfo[15:0];        // see RQ4
      end
    end
  end

  // ================================
  // memory read: check both halves
  // a parity bit plus its half must hold an odd count of ones
  assign parErr = ~(^{memRdWord.parity[1], memRdWord.info[31:16]})
                | ~(^{memRdWord.parity[0], memRdWord.info[15:0]}); // see RQ3, see RQ4

  always_ff @(posedge clk) begin
    if (reset) begin
      rdInfo    <= '0;
      rdTag     <= '0;
      rdValid   <= 1'b0;
      parityIrq <= 1'b0;
    end else begin
      rdValid   <= memRdEn;
      parityIrq <= memRdEn && parErr;                    // see RQ3
      if (memRdEn) begin
        rdInfo <= memRdWord.info;                        // data passed even on error
        rdTag  <= memRdWord.progTag;
      end
    end
  end

  // lamp is sticky; a new error in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      consoleLamp <= 1'b0;
      errCnt_ff   <= '0;
    end else begin
      if (memRdEn && parErr) begin
        consoleLamp <= 1'b1;                             // see RQ3
        errCnt_ff   <= (errCnt_ff == 8'hff) ? errCnt_ff : errCnt_ff + 8'h01;
      end else if (clrLamp) begin
        consoleLamp <= 1'b0;
      end
    end
  end

  // ================================
  // instruction field decode, msb first
  always_ff @(posedge clk) begin
    if (reset) begin
      decodeOut   <= '0;
      decodeValid <= 1'b0;
    end else begin
      decodeValid <= instrValid;
      if (instrValid) begin
        decodeOut.addrField <= instrWord[31:16];         // see RQ6
        decodeOut.indirect  <= instrWord[15];            // see RQ7
        decodeOut.indexSel  <= instrWord[14:12];         // see RQ8
        decodeOut.opCode    <= instrWord[11:0];          // see RQ9
      end
    end
  end

  // ================================
  // operand and control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= '0;
      opA_ff  <= '0;
      opB_ff  <= '0;
    end else if (regWrStb) begin
      if (start) begin
        ctrl_ff <= regWrData[`WFD_C_W-1:0];
      end
      // operands frozen while busy so a running op stays consistent
      if (regAddr == `WFD_A_OPA && state_ff == wfd_pkg::WFD_ST_IDLE) begin
        opA_ff <= regWrData;
      end
      if (regAddr == `WFD_A_OPB && state_ff == wfd_pkg::WFD_ST_IDLE) begin
        opB_ff <= regWrData;
      end
    end
  end

  // ================================
  // single cycle results from the write data path
  logic signed [47:0] product;    // q2.46 product of two fractions
  logic        [15:0] intRes;     // integerized accumulator
  logic        [15:0] byteRes;    // logical byte result
  logic        [15:0] byteMask;   // bits inside selected byte
  logic        [15:0] byteConn;   // connective applied on all bits
  logic        [31:0] fixRes;     // fixed point operand as a word
  logic        [7:0]  shAmt;      // integerize shift count
  logic        [2:0]  sizeSel;    // byte size code
  logic        [3:0]  posSel;     // byte position from the left

  assign product = $signed(opA_ff[31:8]) * $signed(opB_ff[31:8]); // see RQ10
  assign sizeSel = regWrData[`WFD_C_SIZE];
  assign posSel  = regWrData[`WFD_C_POS];

  always_comb begin
    // integer mode store: value = fraction * 2^(exp-23)
    shAmt  = `WFD_EXP_INTMX - opA_ff[7:0];
    intRes = 16'(($signed(opA_ff[31:8])) >>> shAmt[4:0]);         // see RQ19
    if ($signed(opA_ff[7:0]) < 0 || $signed(opA_ff[7:0]) > $signed(`WFD_EXP_INTMX)) begin
      intRes = '0;                                      // out of range stores zero
    end
    // byte select: size 16 >> code, numbered from the left
    byteMask = '0;
    for (int i = 0; i < 16; i++) begin
      if (sizeSel <= 3'h4 && ((4'(15 - i) >> (3'h4 - sizeSel)) == posSel)) begin
        byteMask[i] = 1'b1;                             // see RQ22, see RQ5
      end
    end
    case (regWrData[`WFD_C_CONN])
      2'h0:    byteConn = opA_ff[15:0] & opB_ff[15:0];
      2'h1:    byteConn = opA_ff[15:0] | opB_ff[15:0];
      2'h2:    byteConn = opA_ff[15:0] ^ opB_ff[15:0];
      default: byteConn = opB_ff[15:0];                 // plain move
    endcase
    // recipient keeps its bits outside the byte
    byteRes = regWrData[`WFD_C_DEST] ?
              ((opA_ff[15:0] & ~byteMask) | (byteConn & byteMask)) :
              ((opB_ff[15:0] & ~byteMask) | (byteConn & byteMask)); // see RQ22
    // extended: 30-bit fraction, sign from the left half
    if (regWrData[`WFD_C_EXT]) begin
      fixRes = {{1{opB_ff[31]}}, opB_ff[31:16], opB_ff[14:0]}; // see RQ18
    end else if (regWrData[`WFD_C_DEST]) begin
      fixRes = {{16{opB_ff[31]}}, opB_ff[31:16]};      // see RQ17, left half
    end else begin
      fixRes = {{16{opB_ff[15]}}, opB_ff[15:0]};       // see RQ17, right half
    end
  end

  // ================================
  // sequencer and float accumulator
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff   <= wfd_pkg::WFD_ST_IDLE;
      accFrac_ff <= '0;
      accExp_ff  <= '0;
      floatOp_ff <= 1'b0;
    end else begin
      case (state_ff)
        wfd_pkg::WFD_ST_IDLE: begin
          if (start) begin
            floatOp_ff <= 1'b1;
            // unnormalized modifier skips the shifting phase
            state_ff <= regWrData[`WFD_C_UNORM] ? wfd_pkg::WFD_ST_DONE
                                                : wfd_pkg::WFD_ST_NORM; // see RQ15, see RQ20
            case (newOp)
              wfd_pkg::WFD_OP_NORM: begin
                accFrac_ff <= {opA_ff[31:8], 24'h0};    // see RQ11
                accExp_ff  <= opA_ff[7:0];
              end
              wfd_pkg::WFD_OP_FMUL: begin
                accFrac_ff <= {product[46:0], 1'b0};    // see RQ14
                accExp_ff  <= opA_ff[7:0] + opB_ff[7:0];
              end
              wfd_pkg::WFD_OP_I2F: begin
                accFrac_ff <= {opB_ff[15:0], 32'h0};    // see RQ19
                accExp_ff  <= `WFD_EXP_I2F;
              end
              default: begin
                floatOp_ff <= 1'b0;                     // accumulator left as is
                state_ff   <= wfd_pkg::WFD_ST_DONE;     // see RQ21
              end
            endcase
          end
        end
        wfd_pkg::WFD_ST_NORM: begin
          // stop on differing top bits or an all zero fraction
          if (accFrac_ff[47] != accFrac_ff[46] || accFrac_ff == '0) begin
            state_ff <= wfd_pkg::WFD_ST_DONE;           // see RQ16
          end else begin
            accFrac_ff <= {accFrac_ff[46:0], 1'b0};     // see RQ16
            accExp_ff  <= accExp_ff - 8'h01;
          end
        end
        wfd_pkg::WFD_ST_DONE: begin
          state_ff <= wfd_pkg::WFD_ST_IDLE;
        end
        default: begin
          state_ff <= wfd_pkg::WFD_ST_IDLE;             // recover from a bad code
        end
      endcase
    end
  end

  // ================================
  // result words
  always_ff @(posedge clk) begin
    if (reset) begin
      resHi_ff <= '0;
      resLo_ff <= '0;
    end else if (start) begin
      case (newOp)
        wfd_pkg::WFD_OP_F2I:   resLo_ff <= {16'h0, intRes};
        wfd_pkg::WFD_OP_LBYTE: resLo_ff <= {15'h0, regWrData[`WFD_C_DEST], byteRes};
        wfd_pkg::WFD_OP_FIX:   resLo_ff <= fixRes;
        wfd_pkg::WFD_OP_INDEX: begin
          resLo_ff <= {16'h0, idxReg_ff[regWrData[`WFD_C_IDX]] + opB_ff[15:0]};
        end
        default:               resLo_ff <= resLo_ff;
      endcase
    end else if (state_ff == wfd_pkg::WFD_ST_DONE && floatOp_ff) begin
      // lower address word holds msbs; second word exponent 23 less
      resHi_ff <= {accFrac_ff[47:24], accExp_ff};                    // see RQ12
      resLo_ff <= {1'b0, accFrac_ff[23:1], accExp_ff - `WFD_EXP_LOW}; // see RQ13
    end
  end

  // ================================
  // index registers, updated by index op only
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NIDX; i++) begin
        idxReg_ff[i] <= '0;
      end
    end else if (start && newOp == wfd_pkg::WFD_OP_INDEX) begin
      idxReg_ff[regWrData[`WFD_C_IDX]] <=
        idxReg_ff[regWrData[`WFD_C_IDX]] + opB_ff[15:0]; // see RQ21
    end
  end

  // ================================
  // read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData <= '0;
    end else if (regRdStb) begin
      case (regAddr)
        `WFD_A_CTRL: regRdData <= {{(32-`WFD_C_W){1'b0}}, ctrl_ff};
        `WFD_A_OPA:  regRdData <= opA_ff;
        `WFD_A_OPB:  regRdData <= opB_ff;
        `WFD_A_RESH: regRdData <= resHi_ff;
        `WFD_A_RESL: regRdData <= resLo_ff;
        `WFD_A_STAT: regRdData <= {16'h0, errCnt_ff, 6'h0, consoleLamp,
                                   (state_ff != wfd_pkg::WFD_ST_IDLE)};
        `WFD_A_DEC:  regRdData <= decodeOut;
        default:     regRdData <= '0;                  // unmapped reads zero
      endcase
    end else begin
      regRdData <= '0;
    end
  end

endmodule

/* File: test/wfd_datapath_assertions.sv */
// Purpose: port checks of the word format datapath
// Assumes: one clock, reset synchronous active high
// Notes:   bound into every datapath instance
`timescale 1ns/100ps
module wfd_datapath_assertions #(
  parameter int NIDX = 8
) (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   reset,
  // memory sides
  input wire logic                   memWrEn,
  input wire logic [31:0]            memWrInfo,
  input wire logic [1:0]             memWrTag,
  input wire wfd_pkg::wfd_mem_word_t memWrWord,
  input wire logic                   memWrValid,
  input wire logic                   memRdEn,
  input wire wfd_pkg::wfd_mem_word_t memRdWord,
  input wire logic [31:0]            rdInfo,
  input wire logic                   rdValid,
  input wire logic                   parityIrq,
  input wire logic                   consoleLamp,
  // decode and register port
  input wire logic                   instrValid,
  input wire logic [31:0]            instrWord,
  input wire wfd_pkg::wfd_instr_t    decodeOut,
  input wire logic                   decodeValid,
  input wire logic                   regRdStb,
  input wire logic [31:0]            regRdData
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ========================================
  // helper
  // a half is bad when its ones plus parity come out even
  logic badRd;
  assign badRd = (memRdWord.parity[1] == ^memRdWord.info[31:16])
              || (memRdWord.parity[0] == ^memRdWord.info[15:0]);
  // ========================================
  // assertions
  wr_word_a: assert property (memWrEn |=> memWrValid && memWrWord.info == $past(memWrInfo)
    && memWrWord.progTag == $past(memWrTag)) else $error("stored word differs from input");
  wr_pulse_a: assert property (memWrValid |-> $past(memWrEn)) else $error("write valid unasked");
  wr_parity_a: assert property (memWrValid |-> memWrWord.parity ==
    {~^memWrWord.info[31:16], ~^memWrWord.info[15:0]}) else $error("write parity wrong");
  rd_data_a: assert property (memRdEn |=> rdValid && rdInfo == $past(memRdWord.info))
    else $error("read data wrong");
  par_irq_a: assert property (memRdEn |=> parityIrq == $past(badRd))
    else $error("parity interrupt wrong");
  irq_cause_a: assert property (parityIrq |-> $past(memRdEn) && $past(badRd))
    else $error("parity interrupt without cause");
  lamp_on_a: assert property (parityIrq |-> consoleLamp) else $error("lamp dark");
  dec_field_a: assert property (instrValid |=> decodeValid ##0
    decodeOut == $past(instrWord)) else $error("decode fields wrong");
  rd_idle_a: assert property (!regRdStb |=> regRdData == 32'h0) else $error("read data left");
  // ========================================
  // covers
  par_err_c: cover property (memRdEn && badRd);
  wr_c: cover property (memWrEn ##1 memWrValid);
  dec_c: cover property (instrValid && instrWord[15]);
endmodule

bind wfd_datapath wfd_datapath_assertions #(.NIDX(NIDX)) chk (.clk, .reset, .memWrEn,
  .memWrInfo, .memWrTag, .memWrWord, .memWrValid, .memRdEn, .memRdWord, .rdInfo, .rdValid,
  .parityIrq, .consoleLamp, .instrValid, .instrWord, .decodeOut, .decodeValid, .regRdStb,
  .regRdData);

/* File: test/wfd_core_bank.sv */
// Purpose: behavioural core memory bank facing the datapath
// Assumes: one word cell; the bench picks what is read back
// Notes:   flipPar injects parity faults only when the bench asks
`timescale 1ns/100ps
module wfd_core_bank (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // write side
  input  wire logic                   memWrValid,
  input  wire wfd_pkg::wfd_mem_word_t memWrWord,
  // read side
  input  wire logic                   memRdEn,
  input  wire logic [1:0]             flipPar,
  output wfd_pkg::wfd_mem_word_t      memRdWord
);
  wfd_pkg::wfd_mem_word_t cell_ff; // one stored 36 bit word
  // ========================================
  // store every bit, parity and tags too
  always_ff @(posedge clk) begin
    if (reset) begin
      cell_ff <= '0;
    end else if (memWrValid) begin
      cell_ff <= memWrWord;
    end
  end
  // idle bus shows the inverse so a stale copy never passes
  always_comb begin
    memRdWord = ~cell_ff;
    if (memRdEn) begin
      memRdWord        = cell_ff;
      memRdWord.parity = cell_ff.parity ^ flipPar;
    end
  end
endmodule

/* File: test/testbench.sv */
// Purpose: self checking bench of the word format datapath
// Assumes: register reads answer one cycle after the strobe
// Notes:   expectations worked out by hand from the word layouts
`timescale 1ns/100ps
`include "wfd_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %0t got %h expected %h", $time, got, exp); end end
module testbench;
  logic clk, reset, regWrStb, regRdStb, memWrEn, memRdEn, instrValid;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData, memWrInfo, rdInfo, instrWord;
  logic [1:0]  memWrTag, rdTag, flipPar;
  logic        memWrValid, rdValid, parityIrq, consoleLamp, decodeValid;
  wfd_pkg::wfd_mem_word_t memWrWord, memRdWord;
  wfd_pkg::wfd_instr_t    decodeOut;
  int errors, n_compared;
  wfd_datapath #(.NIDX(8)) dut (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .memWrEn(memWrEn), .memWrInfo(memWrInfo), .memWrTag(memWrTag), .memWrWord(memWrWord),
    .memWrValid(memWrValid), .memRdEn(memRdEn), .memRdWord(memRdWord), .rdInfo(rdInfo),
    .rdTag(rdTag), .rdValid(rdValid), .parityIrq(parityIrq), .consoleLamp(consoleLamp),
    .instrValid(instrValid), .instrWord(instrWord), .decodeOut(decodeOut),
    .decodeValid(decodeValid));
  wfd_core_bank bank (.clk(clk), .reset(reset), .memWrValid(memWrValid),
    .memWrWord(memWrWord), .memRdEn(memRdEn), .flipPar(flipPar), .memRdWord(memRdWord));
  always #4 clk = ~clk;
  // ========================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrStb  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic mem_rd(input logic [1:0] f);
    @(posedge clk);
    memRdEn <= 1'b1;
    flipPar <= f;
    @(posedge clk);
    memRdEn <= 1'b0;
    #1 `CHK(rdValid, 1'b1)
  endtask
  // start one operation, poll busy, then fetch both result words
  task automatic run_op(input logic [31:0] c, output logic [31:0] h, l);
    logic [31:0] s;
    wr(`WFD_A_CTRL, c);
    s = 32'h1;
    while (s[`WFD_S_BUSY]) rd(`WFD_A_STAT, s);
    rd(`WFD_A_RESH, h);
    rd(`WFD_A_RESL, l);
  endtask
  // ========================================
  // scenarios
  task automatic t_mem_write();
    logic [31:0] v[4] = '{32'h0, 32'hffffffff, 32'h00010000, 32'h80000003};
    logic [1:0]  p[4] = '{2'h3, 2'h3, 2'h1, 2'h1};
    foreach (v[i]) begin
      @(posedge clk);
      memWrEn   <= 1'b1;
      memWrInfo <= v[i];
      memWrTag  <= i[1:0];
      @(posedge clk);
      memWrEn   <= 1'b0;
      #1 `CHK(memWrValid, 1'b1)
      `CHK(memWrWord.info, v[i])
      `CHK(memWrWord.progTag, i[1:0])
      `CHK(memWrWord.parity, p[i])
    end
  endtask
  task automatic t_mem_read();
    logic [31:0] s;
    mem_rd(2'h0);
    `CHK({rdTag, rdInfo}, {2'h3, 32'h80000003})
    `CHK({parityIrq, consoleLamp}, 2'h0)
    mem_rd(2'h2);
    `CHK(rdInfo, 32'h80000003)
    `CHK({parityIrq, consoleLamp}, 2'h3)
    mem_rd(2'h1);
    rd(`WFD_A_STAT, s);
    `CHK({s[`WFD_S_CNT], s[`WFD_S_LAMP]}, {8'h02, 1'b1})
    wr(`WFD_A_STAT, 32'h2);
    rd(`WFD_A_STAT, s);
    `CHK({s[`WFD_S_CNT], s[`WFD_S_LAMP], consoleLamp}, {8'h02, 2'h0})
  endtask
  task automatic t_decode();
    logic [31:0] w[2] = '{32'h1234a5c6, 32'hffff7fff};
    logic [31:0] s;
    foreach (w[i]) begin
      @(posedge clk);
      instrValid <= 1'b1;
      instrWord  <= w[i];
      @(posedge clk);
      instrValid <= 1'b0;
      #1 `CHK(decodeValid, 1'b1)
      `CHK(decodeOut.addrField, w[i][31:16])
      `CHK(decodeOut.indirect, w[i][15])
      `CHK(decodeOut.indexSel, w[i][14:12])
      `CHK(decodeOut.opCode, w[i][11:0])
      rd(`WFD_A_DEC, s);
      `CHK(s, w[i])
    end
  endtask
  task automatic t_index();
    logic [31:0] s;
    wr(`WFD_A_OPA, 32'h1357);
    wr(`WFD_A_OPB, 32'h5);
    // start and a refused accumulator write with no gap
    @(posedge clk);
    regWrStb  <= 1'b1;
    regAddr   <= `WFD_A_CTRL;
    regWrData <= 32'h34;
    @(posedge clk);
    regAddr   <= `WFD_A_OPA;
    regWrData <= 32'h0;
    @(posedge clk);
    regWrStb  <= 1'b0;
    rd(`WFD_A_RESL, s);
    `CHK(s[15:0], 16'h0005)
    rd(`WFD_A_OPA, s);
    `CHK(s, 32'h1357)
    wr(`WFD_A_OPB, 32'hfffe);
    wr(`WFD_A_CTRL, 32'h34);
    repeat (2) @(posedge clk);
    rd(`WFD_A_RESL, s);
    `CHK(s[15:0], 16'h0003)
    rd(8'h40, s);
    `CHK(s, 32'h0)
  endtask
  task automatic t_lbyte();
    logic [31:0] s, c;
    logic [7:0]  e[4] = '{8'h04, 8'h3f, 8'h3b, 8'h0f};
    wr(`WFD_A_OPB, 32'hff0f);
    for (int k = 0; k < 5; k++) begin
      c = 32'h0;
      c[`WFD_C_OP]   = 3'h5;
      c[`WFD_C_SIZE] = 3'h1;
      c[`WFD_C_POS]  = 4'h1;
      c[`WFD_C_CONN] = k[1:0];
      c[`WFD_C_DEST] = (k < 4);
      wr(`WFD_A_OPA, 32'h1234);
      wr(`WFD_A_CTRL, c);
      repeat (2) @(posedge clk);
      rd(`WFD_A_RESL, s);
      if (k < 4) `CHK(s[16:0], {1'b1, 8'h12, e[k]})
      else `CHK(s[16:0], {1'b0, 8'hff, 8'h04})
    end
  endtask
  // float ops: integer load and multiply, both with and without modifier, then normalize without it
  task automatic t_float();
    logic [31:0] h, l;
    wr(`WFD_A_OPB, 32'h1);
    run_op(32'h2, h, l);
    `CHK({h, l}, {32'h40000001, 32'h000000ea})
    run_op(32'ha, h, l);
    `CHK({h, l}, {32'h0001000f, 32'h000000f8})
    wr(`WFD_A_OPA, 32'h40000001);
    wr(`WFD_A_OPB, 32'h40000002);
    run_op(32'h9, h, l);
    `CHK({h, l}, {32'h20000003, 32'h000000ec})
    run_op(32'h1, h, l);
    `CHK({h, l}, {32'h40000002, 32'h000000eb})
    wr(`WFD_A_OPA, 32'he0000003);
    run_op(32'h0, h, l);
    `CHK({h, l}, {32'h80000001, 32'h000000ea})
  endtask
  // integer store, fixed point halves and the empty op
  task automatic t_fixed();
    logic [31:0] h, l;
    wr(`WFD_A_OPA, 32'h80000001);
    run_op(32'h3, h, l);
    `CHK(l, 32'h0000fffe)
    wr(`WFD_A_OPA, 32'h40000018);
    run_op(32'h3, h, l);
    `CHK(l, 32'h00000000)
    wr(`WFD_A_OPB, 32'h80014003);
    run_op(32'h40006, h, l);
    `CHK(l, 32'hc000c003)
    run_op(32'h20006, h, l);
    `CHK(l, 32'hffff8001)
    run_op(32'h6, h, l);
    `CHK(l, 32'h00004003)
    run_op(32'h7, h, l);
    `CHK({h, l}, {32'h80000001, 32'h00004003})
  endtask
  // ========================================
  // verdict and run control
  task automatic finish_test();
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    {clk, regWrStb, regRdStb, memWrEn, memRdEn, instrValid} = '0;
    {regAddr, regWrData, memWrInfo, memWrTag, instrWord, flipPar} = '0;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_mem_write();
    t_mem_read();
    t_decode();
    t_index();
    t_lbyte();
    t_float();
    t_fixed();
    finish_test();
  end
endmodule
